// >>> common/led_i2c_pkg.sv
`default_nettype none
package led_i2c_pkg;
    localparam logic [6:0] slave_addr = 7'h39;
    localparam logic [7:0] sel_backlight = 8'h01;
    localparam logic [7:0] sel_flash = 8'h02;
    localparam logic [7:0] reg_reset = 8'h00;
    localparam int fourth_led_bit = 7;
    localparam logic [4:0] backlight_full_code = 5'h1f;
    localparam logic [6:0] flash_full_code = 7'h7f;
    localparam logic [3:0] bit_count_reset = 4'h0;
    localparam logic [3:0] last_data_bit = 4'h7;
    localparam logic [3:0] data_bits = 4'h8;
    localparam logic [3:0] ack_slot = 4'h9;

    typedef enum logic [2:0] {st_idle, st_addr, st_sel, st_code, st_skip} phase_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } pins_t;

    typedef struct packed {
        logic converter_on;
        logic [3:0] backlight_led_on;
        logic [3:0] flash_led_on;
        logic [4:0] backlight_current_code;
        logic [6:0] flash_current_code;
    } drive_t;
endpackage : led_i2c_pkg
`default_nettype wire

// >>> core/led_current_i2c_slave.sv
`default_nettype none
module led_current_i2c_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    // Stored registers and LED drive
    output logic [7:0] backlight_current_reg,
    output logic [7:0] flash_current_reg,
    output led_i2c_pkg::drive_t drive
);
    typedef struct packed {
        led_i2c_pkg::pins_t s1;
        led_i2c_pkg::pins_t s2;
        led_i2c_pkg::pins_t prev;
        led_i2c_pkg::phase_t phase;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic [7:0] sel;
        logic ack;
        logic [7:0] bk;
        logic [7:0] fl;
        led_i2c_pkg::drive_t drv;
    } state_t;

    state_t st_r, st_nxt;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] byte_now;

    function automatic led_i2c_pkg::drive_t derive(input logic [7:0] bk, input logic [7:0] fl);
        led_i2c_pkg::drive_t d;
        d.backlight_current_code = bk[4:0];
        d.flash_current_code = fl[6:0];
        d.converter_on = (bk != 8'h00) || (fl != 8'h00);
        d.backlight_led_on = (bk == 8'h00) ? 4'h0 : {bk[led_i2c_pkg::fourth_led_bit], 3'h7};
        d.flash_led_on = (fl == 8'h00) ? 4'h0 : 4'hf;
        return d;
    endfunction : derive

    // Pins pass two flops; edges are found on the second stage only.
    assign scl_rise = st_r.s2.scl && !st_r.prev.scl;
    assign scl_fall = !st_r.s2.scl && st_r.prev.scl;
    assign start_seen = st_r.s2.scl && st_r.prev.scl && !st_r.s2.sda && st_r.prev.sda;
    assign stop_seen = st_r.s2.scl && st_r.prev.scl && st_r.s2.sda && !st_r.prev.sda;
    assign byte_now = {st_r.shift[6:0], st_r.s2.sda};

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = '{scl: scl_in, sda: sda_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        if (start_seen) begin
            st_nxt.phase = led_i2c_pkg::st_addr;
            st_nxt.bitcnt = led_i2c_pkg::bit_count_reset;
            st_nxt.ack = 1'b0;
        end else if (stop_seen) begin
            st_nxt.phase = led_i2c_pkg::st_idle;
            st_nxt.ack = 1'b0;
        end else if (st_r.phase != led_i2c_pkg::st_idle && st_r.phase != led_i2c_pkg::st_skip) begin
            if (scl_rise && st_r.bitcnt < led_i2c_pkg::data_bits) begin
                st_nxt.shift = byte_now;
                st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                if (st_r.bitcnt == led_i2c_pkg::last_data_bit) begin
                    case (st_r.phase)
                        led_i2c_pkg::st_addr: begin
                            if (byte_now[7:1] == led_i2c_pkg::slave_addr && !byte_now[0]) begin
                                st_nxt.phase = led_i2c_pkg::st_sel;
                            end else begin
                                st_nxt.phase = led_i2c_pkg::st_skip;
                            end
                        end
                        led_i2c_pkg::st_sel: begin
                            st_nxt.sel = byte_now;
                            st_nxt.phase = led_i2c_pkg::st_code;
                        end
                        led_i2c_pkg::st_code: begin
                            // Load happens on the eighth rising edge, before the acknowledge.
                            if (st_r.sel == led_i2c_pkg::sel_backlight) begin
                                st_nxt.bk = byte_now;
                            end else if (st_r.sel == led_i2c_pkg::sel_flash) begin
                                st_nxt.fl = byte_now;
                            end
                            st_nxt.phase = led_i2c_pkg::st_sel;
                        end
                        default: begin
                            st_nxt.phase = st_r.phase;
                        end
                    endcase
                end
            end
            if (scl_fall && st_r.bitcnt == led_i2c_pkg::data_bits) begin
                // Acknowledge only bytes that reached a valid next phase.
                st_nxt.ack = st_r.phase != led_i2c_pkg::st_skip;
                st_nxt.bitcnt = led_i2c_pkg::ack_slot;
            end else if (scl_fall && st_r.bitcnt == led_i2c_pkg::ack_slot) begin
                st_nxt.ack = 1'b0;
                st_nxt.bitcnt = led_i2c_pkg::bit_count_reset;
            end
        end else if (st_r.phase == led_i2c_pkg::st_skip) begin
            st_nxt.ack = 1'b0;
        end
        st_nxt.drv = derive(st_nxt.bk, st_nxt.fl);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.s1 <= '{scl: 1'b1, sda: 1'b1};
            st_r.s2 <= '{scl: 1'b1, sda: 1'b1};
            st_r.prev <= '{scl: 1'b1, sda: 1'b1};
            st_r.phase <= led_i2c_pkg::st_idle;
            st_r.bk <= led_i2c_pkg::reg_reset;
            st_r.fl <= led_i2c_pkg::reg_reset;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = st_r.ack;
    assign scl_out = 1'b0;
    assign scl_oe = 1'b0;
    assign backlight_current_reg = st_r.bk;
    assign flash_current_reg = st_r.fl;
    assign drive = st_r.drv;

    a_clock_never_driven: assert property (@(posedge clk) disable iff (srst) !scl_oe)
        else $error("clock line driven");
    a_zero_converter_off: assert property (@(posedge clk) disable iff (srst)
        (st_r.bk == 8'h00 && st_r.fl == 8'h00) |-> (!drive.converter_on && drive.flash_led_on == 4'h0
        && drive.backlight_led_on == 4'h0))
        else $error("converter on with zero registers");
    a_nonzero_converter_on: assert property (@(posedge clk) disable iff (srst)
        (st_r.bk != 8'h00 || st_r.fl != 8'h00) |-> drive.converter_on)
        else $error("converter off with nonzero register");
    a_fourth_led_bit: assert property (@(posedge clk) disable iff (srst)
        (st_r.bk != 8'h00) |-> (drive.backlight_led_on == {st_r.bk[7], 3'h7}))
        else $error("fourth led mismatch");
    a_flash_leds_on: assert property (@(posedge clk) disable iff (srst)
        (st_r.fl != 8'h00) |-> (drive.flash_led_on == 4'hf))
        else $error("flash leds off with nonzero register");
    a_backlight_code_live: assert property (@(posedge clk) disable iff (srst)
        drive.backlight_current_code == st_r.bk[4:0])
        else $error("backlight code not from register");
    a_flash_code_live: assert property (@(posedge clk) disable iff (srst)
        drive.flash_current_code == st_r.fl[6:0])
        else $error("flash code not from register");

    // The registers are flops, so each load check looks one cycle after the decoded edge.
    a_regs_hold_quiet: assert property (@(posedge clk) disable iff (srst)
        !(scl_rise && st_r.phase == led_i2c_pkg::st_code) |=> ($stable(st_r.bk) && $stable(st_r.fl)))
        else $error("register changed outside load edge");
    a_load_backlight: assert property (@(posedge clk) disable iff (srst)
        (scl_rise && st_r.phase == led_i2c_pkg::st_code && st_r.bitcnt == led_i2c_pkg::last_data_bit
        && st_r.sel == led_i2c_pkg::sel_backlight) |=> (st_r.bk == $past(byte_now)))
        else $error("backlight register not loaded");
    a_load_flash: assert property (@(posedge clk) disable iff (srst)
        (scl_rise && st_r.phase == led_i2c_pkg::st_code && st_r.bitcnt == led_i2c_pkg::last_data_bit
        && st_r.sel == led_i2c_pkg::sel_flash) |=> (st_r.fl == $past(byte_now)))
        else $error("flash register not loaded");
    a_bad_sel_ignored: assert property (@(posedge clk) disable iff (srst)
        (st_r.sel != led_i2c_pkg::sel_backlight && st_r.sel != led_i2c_pkg::sel_flash)
        |=> ($stable(st_r.bk) && $stable(st_r.fl)))
        else $error("register changed on undefined select");
    // Reset is watched without the disable so that a register that ignores it still shows.
    a_reset_clears: assert property (@(posedge clk)
        srst |=> (st_r.bk == led_i2c_pkg::reg_reset && st_r.fl == led_i2c_pkg::reg_reset
        && !drive.converter_on && !sda_oe))
        else $error("reset left state behind");

    a_shift_msb_first: assert property (@(posedge clk) disable iff (srst)
        (scl_rise && st_r.bitcnt < led_i2c_pkg::data_bits && st_r.phase != led_i2c_pkg::st_idle
        && st_r.phase != led_i2c_pkg::st_skip) |=> (st_r.shift == {$past(st_r.shift[6:0]), $past(st_r.s2.sda)}))
        else $error("bit not shifted in msb first");
    a_bitcnt_bounded: assert property (@(posedge clk) disable iff (srst)
        st_r.bitcnt <= led_i2c_pkg::ack_slot)
        else $error("bit counter out of range");
    a_sel_captured: assert property (@(posedge clk) disable iff (srst)
        (scl_rise && st_r.phase == led_i2c_pkg::st_sel && st_r.bitcnt == led_i2c_pkg::last_data_bit)
        |=> (st_r.sel == $past(byte_now) && st_r.phase == led_i2c_pkg::st_code))
        else $error("bank select not captured");
    a_own_addr_taken: assert property (@(posedge clk) disable iff (srst)
        (scl_rise && st_r.phase == led_i2c_pkg::st_addr && st_r.bitcnt == led_i2c_pkg::last_data_bit
        && byte_now == {led_i2c_pkg::slave_addr, 1'h0}) |=> (st_r.phase == led_i2c_pkg::st_sel))
        else $error("own address not taken");
    a_foreign_addr_dropped: assert property (@(posedge clk) disable iff (srst)
        (scl_rise && st_r.phase == led_i2c_pkg::st_addr && st_r.bitcnt == led_i2c_pkg::last_data_bit
        && byte_now != {led_i2c_pkg::slave_addr, 1'h0}) |=> (st_r.phase == led_i2c_pkg::st_skip))
        else $error("foreign address not dropped");
    a_start_restarts: assert property (@(posedge clk) disable iff (srst)
        start_seen |=> (st_r.phase == led_i2c_pkg::st_addr
        && st_r.bitcnt == led_i2c_pkg::bit_count_reset && !sda_oe))
        else $error("start did not restart the frame");
    a_stop_ends_frame: assert property (@(posedge clk) disable iff (srst)
        stop_seen |=> (st_r.phase == led_i2c_pkg::st_idle && !sda_oe))
        else $error("frame not ended by stop");

    a_ack_raised: assert property (@(posedge clk) disable iff (srst)
        (scl_fall && st_r.bitcnt == led_i2c_pkg::data_bits && (st_r.phase == led_i2c_pkg::st_sel
        || st_r.phase == led_i2c_pkg::st_code)) |=> sda_oe)
        else $error("acknowledge missing");
    a_ack_released: assert property (@(posedge clk) disable iff (srst)
        (scl_fall && st_r.bitcnt == led_i2c_pkg::ack_slot) |=> !sda_oe)
        else $error("acknowledge not released");
    a_ack_only_pull: assert property (@(posedge clk) disable iff (srst)
        sda_oe |-> (st_r.bitcnt == led_i2c_pkg::ack_slot && !sda_out))
        else $error("sda driven outside acknowledge");
    a_ack_in_frame: assert property (@(posedge clk) disable iff (srst)
        sda_oe |-> (st_r.phase == led_i2c_pkg::st_sel || st_r.phase == led_i2c_pkg::st_code))
        else $error("acknowledge outside a write frame");
    a_wrong_addr_skip: assert property (@(posedge clk) disable iff (srst)
        (st_r.phase == led_i2c_pkg::st_skip) |-> !sda_oe)
        else $error("acknowledge after foreign address");
    a_skip_holds_regs: assert property (@(posedge clk) disable iff (srst)
        (st_r.phase == led_i2c_pkg::st_skip) |=> ($stable(st_r.bk) && $stable(st_r.fl)))
        else $error("register changed after foreign address");
endmodule : led_current_i2c_slave
`default_nettype wire

// >>> tb/i2c_host_model.sv
`default_nettype none
module i2c_host_model (
    // Clock and bus
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Released SDA reads high through the pull-up, so a missing ACK shows as a zero in acks.
    task automatic frame(input logic [23:0] b, input int n, output logic [2:0] acks);
        acks = 3'h0;
        sda = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(2);
        for (int k = 0; k < n; k++) begin
            for (int i = 8; i >= 0; i--) begin
                sda = (i == 0) ? 1'b1 : b[15 - 8 * k + i];
                tick(2);
                scl = 1'b1;
                tick(2);
                acks[2 - k] = ~sda_line;
                tick(2);
                scl = 1'b0;
                tick(2);
            end
        end
        sda = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda = 1'b1;
        tick(8);
    endtask : frame
endmodule : i2c_host_model
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic scl, sda, sda_out, sda_oe, scl_out, scl_oe;
    logic [7:0] bl_reg, fl_reg;
    logic [2:0] acks;
    led_i2c_pkg::drive_t drive;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    // Open-drain lines with pull-ups: an enabled driver whose output is low pulls the wire low.
    wire logic sda_line = sda & ~(sda_oe & ~sda_out);
    wire logic scl_line = scl & ~(scl_oe & ~scl_out);
    always #12.5 clk = ~clk;
    led_current_i2c_slave led_current_i2c_slave_inst (.clk(clk), .srst(srst), .scl_in(scl_line),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
        .backlight_current_reg(bl_reg), .flash_current_reg(fl_reg), .drive(drive));
    i2c_host_model i2c_host_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic expect_state(input logic [7:0] bl, input logic [7:0] fl);
        chk("bl reg", bl, bl_reg);
        chk("fl reg", fl, fl_reg);
        chk("converter", {7'h0, |{bl, fl}}, {7'h0, drive.converter_on});
        chk("bl leds", (bl == 8'h0) ? 8'h0 : {4'h0, bl[7], 3'h7}, {4'h0, drive.backlight_led_on});
        chk("fl leds", (fl == 8'h0) ? 8'h0 : 8'h0f, {4'h0, drive.flash_led_on});
        chk("bl code", {3'h0, bl[4:0]}, {3'h0, drive.backlight_current_code});
        chk("fl code", {1'h0, fl[6:0]}, {1'h0, drive.flash_current_code});
    endtask : expect_state
    task automatic wr(input logic [7:0] sel, input logic [7:0] code, input logic [7:0] bl, input logic [7:0] fl);
        i2c_host_model_inst.frame({8'h72, sel, code}, 3, acks);
        chk("acks", 8'h07, {5'h0, acks});
        expect_state(bl, fl);
    endtask : wr
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        repeat (3) @(posedge clk);
        #1 expect_state(8'h00, 8'h00);
        wr(8'h01, 8'h85, 8'h85, 8'h00);
        wr(8'h01, 8'h1f, 8'h1f, 8'h00);
        wr(8'h02, 8'h7f, 8'h1f, 8'h7f);
        wr(8'h03, 8'h55, 8'h1f, 8'h7f);
        wr(8'h00, 8'h55, 8'h1f, 8'h7f);
        i2c_host_model_inst.frame({8'h74, 8'h01, 8'h00}, 3, acks);
        chk("acks", 8'h00, {5'h0, acks});
        i2c_host_model_inst.frame({8'h73, 8'h01, 8'h00}, 3, acks);
        chk("acks", 8'h00, {5'h0, acks});
        i2c_host_model_inst.frame({8'h72, 8'h01, 8'h00}, 2, acks);
        expect_state(8'h1f, 8'h7f);
        wr(8'h01, 8'h80, 8'h80, 8'h7f);
        wr(8'h02, 8'h00, 8'h80, 8'h00);
        wr(8'h01, 8'h00, 8'h00, 8'h00);
        chk("scl oe", 8'h00, {7'h0, scl_oe});
        chk("sda oe", 8'h00, {7'h0, sda_oe});
        chk("scl out", 8'h00, {7'h0, scl_out});
        chk("sda out", 8'h00, {7'h0, sda_out});
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
